// >>> hdl/pbs_burst_port.sv
// Pin-level model of a pipelined burst static memory with two-bit burst counter.
// Assumes all pins except out_drive_n and sleep_request are synchronous to sys_clk;
// the data pins are split into in, out and a single output enable.
`timescale 1ns/1ps

module pbs_burst_port (
  // Clock, reset, enable.
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Address and controls.
  input wire logic [pbs_pkg::HI_W-1:0] addr_hi,
  input wire logic burst_addr_bit1,
  input wire logic burst_addr_bit0,
  input wire pbs_pkg::pbs_ctrl_t ctrl,
  // Asynchronous and static pins.
  input wire logic out_drive_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  // Data and parity pins.
  input wire pbs_pkg::pbs_data_t data_in,
  output pbs_pkg::pbs_data_t data_out,
  output logic data_oe
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Lanes written by one set of write inputs; empty means a read.
  function automatic logic [pbs_pkg::LANES-1:0] lane_mask(input logic gw_n,
                                                          input logic qual_n,
                                                          input logic [pbs_pkg::LANES-1:0] sel_n);
    if (!gw_n) begin
      lane_mask = pbs_pkg::LANES_ALL;
    end else if (!qual_n) begin
      lane_mask = ~sel_n;
    end else begin
      lane_mask = pbs_pkg::LANES_NONE;
    end
  endfunction

  function automatic pbs_pkg::pbs_word_t merge(input pbs_pkg::pbs_word_t old_w,
                                               input pbs_pkg::pbs_word_t new_w,
                                               input logic [pbs_pkg::LANES-1:0] mask);
    merge = old_w;
    for (int l = 0; l < pbs_pkg::LANES; l++) begin
      if (mask[l]) begin
        merge[l] = new_w[l];
      end
    end
  endfunction

  function automatic logic [pbs_pkg::LO_W-1:0] burst_lo(input logic [pbs_pkg::LO_W-1:0] start,
                                                        input logic [pbs_pkg::LO_W-1:0] step,
                                                        input logic order);
    if (order == pbs_pkg::ORDER_LINEAR) begin
      burst_lo = start + step;
    end else begin
      burst_lo = start ^ step;
    end
  endfunction

  // ****************************************
  // Storage and pin packing
  // ****************************************

  pbs_pkg::pbs_word_t mem [0:pbs_pkg::DEPTH-1];
  pbs_pkg::pbs_regs_t r;
  pbs_pkg::pbs_regs_t nxt;
  pbs_pkg::pbs_word_t pin_word;
  logic [pbs_pkg::LO_W-1:0] ld_lo;
  logic [pbs_pkg::ADDR_W-1:0] cur_addr;
  logic [pbs_pkg::ADDR_W-1:0] acc_addr;
  logic [pbs_pkg::LANES-1:0] acc_mask;
  logic [pbs_pkg::LANES-1:0] ld_mask;
  logic [pbs_pkg::LANES-1:0] run_mask;
  logic do_acc;
  logic proc_ok;
  logic load;
  logic sel;

  genvar l;
  generate
    for (l = 0; l < pbs_pkg::LANES; l++) begin : g_lane
      assign pin_word[l] = {data_in.parity_lines[l],
                            data_in.dq[l*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W]};
      assign data_out.dq[l*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W] = r.dout[l][pbs_pkg::BYTE_W-1:0];
      assign data_out.parity_lines[l] = r.dout[l][pbs_pkg::BYTE_W];
    end
  endgenerate

  // ****************************************
  // Strobe and select decode
  // ****************************************

  assign ld_lo = {burst_addr_bit1, burst_addr_bit0};
  assign proc_ok = !ctrl.proc_addr_strobe_n && !ctrl.select_first_n;
  assign load = proc_ok || !ctrl.ctrl_addr_strobe_n;
  assign sel = !ctrl.select_first_n && ctrl.select_second && !ctrl.select_third_n;
  assign cur_addr = {r.addr_hi, burst_lo(r.start, r.step, r.order)};
  assign run_mask = lane_mask(ctrl.all_lanes_write_n, ctrl.lane_write_qualify_n,
                              ctrl.lane_write_sel_n);
  // The processor strobe's first cycle ignores the write inputs.
  assign ld_mask = proc_ok ? pbs_pkg::LANES_NONE : run_mask;

  // ****************************************
  // Next state
  // ****************************************

  always_comb begin
    nxt = r;
    nxt.wr_pend = 1'b0;
    nxt.wr_seen = 1'b0;
    nxt.first = 1'b0;
    do_acc = 1'b0;
    acc_addr = cur_addr;
    acc_mask = run_mask;
    // The strap is caught once after reset release and then held.
    if (!r.order_taken) begin
      nxt.order = burst_order;
      nxt.order_taken = 1'b1;
    end
    if (sleep_request) begin
      nxt.st = pbs_pkg::PBS_IDLE;
      nxt.drive = 1'b0;
    end else if (load && sel) begin
      nxt.st = pbs_pkg::PBS_ACTIVE;
      nxt.addr_hi = addr_hi;
      nxt.start = ld_lo;
      nxt.step = pbs_pkg::STEP_ZERO;
      nxt.first = (r.st != pbs_pkg::PBS_ACTIVE) && (ld_mask == pbs_pkg::LANES_NONE);
      do_acc = 1'b1;
      acc_addr = {addr_hi, ld_lo};
      acc_mask = ld_mask;
    end else if (load) begin
      // Deselect keeps the last data driven for one more cycle.
      nxt.st = (r.st == pbs_pkg::PBS_ACTIVE) ? pbs_pkg::PBS_DRAIN : pbs_pkg::PBS_IDLE;
      nxt.drive = (r.st == pbs_pkg::PBS_ACTIVE) && r.drive;
    end else begin
      case (r.st)
        pbs_pkg::PBS_ACTIVE: begin
          do_acc = 1'b1;
          if (!ctrl.burst_step_n) begin
            nxt.step = r.step + pbs_pkg::STEP_ONE;
          end
          // The access uses the stepped counter, so an advance shows the next location.
          acc_addr = {r.addr_hi, burst_lo(r.start, nxt.step, r.order)};
        end
        pbs_pkg::PBS_DRAIN: begin
          nxt.st = pbs_pkg::PBS_IDLE;
          nxt.drive = 1'b0;
        end
        pbs_pkg::PBS_IDLE: begin
          nxt.drive = 1'b0;
        end
        default: begin
          nxt.st = pbs_pkg::PBS_IDLE;
          nxt.drive = 1'b0;
        end
      endcase
    end
    if (do_acc) begin
      if (acc_mask != pbs_pkg::LANES_NONE) begin
        nxt.wr_pend = 1'b1;
        nxt.wr_seen = 1'b1;
        nxt.wr_addr = acc_addr;
        nxt.wr_mask = acc_mask;
        nxt.din = pin_word;
        nxt.drive = 1'b0;
      end else begin
        // Writes land one edge late, so a read of that location is forwarded.
        if (r.wr_pend && r.wr_addr == acc_addr) begin
          nxt.dout = merge(mem[acc_addr], r.din, r.wr_mask);
        end else begin
          nxt.dout = mem[acc_addr];
        end
        nxt.drive = 1'b1;
      end
    end
  end

  // ****************************************
  // State registers and memory
  // ****************************************

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: pbs_pkg::PBS_IDLE, order: pbs_pkg::ORDER_INTERLEAVED, default: '0};
    end else if (clk_en) begin
      r <= nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && r.wr_pend) begin
      mem[r.wr_addr] <= merge(mem[r.wr_addr], r.din, r.wr_mask);
    end
  end

  // The enable pin acts without the clock; sleep and writes override it.
  assign data_oe = r.drive && !r.first && !r.wr_seen && !out_drive_n && !sleep_request;

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_live;
    clk_en && !sleep_request;
  endsequence

  // A burst continue cycle: active and no recognised strobe.
  sequence s_continue;
    s_live ##0 !load && r.st == pbs_pkg::PBS_ACTIVE;
  endsequence

  // A recognised strobe with the port selected starts a new access.
  sequence s_select_load;
    s_live ##0 load && sel;
  endsequence

  sequence s_desel_active;
    s_live ##0 load && !sel && r.st == pbs_pkg::PBS_ACTIVE;
  endsequence

  // Frozen edges change nothing and sleeping edges force the port idle, so every check but a_write_tristate and a_sleep_quiet starts from a live edge.
  a_addr_capture: assert property (
    s_select_load
    |=> r.addr_hi == $past(addr_hi) && r.start == $past(ld_lo) && r.step == pbs_pkg::STEP_ZERO)
    else $error("address not captured on strobe");
  a_chip_decode: assert property (
    s_live ##0 load && !sel
    |=> r.st != pbs_pkg::PBS_ACTIVE)
    else $error("deselected port went active");
  a_proc_ignored: assert property (
    s_live ##0 ctrl.select_first_n && ctrl.ctrl_addr_strobe_n
    |=> r.addr_hi == $past(r.addr_hi) && r.start == $past(r.start))
    else $error("processor strobe taken while first select high");
  a_proc_priority: assert property (
    s_live ##0 proc_ok && sel
    |=> !r.wr_pend && r.drive)
    else $error("processor strobe cycle did not read");
  a_burst_step: assert property (
    s_continue ##0 !ctrl.burst_step_n
    |=> r.step == $past(r.step) + pbs_pkg::STEP_ONE)
    else $error("burst counter did not step");
  a_burst_hold: assert property (
    s_continue ##0 ctrl.burst_step_n
    |=> r.step == $past(r.step))
    else $error("burst counter moved without advance");
  a_lane_write: assert property (
    s_live ##0 (load ? sel && !proc_ok : r.st == pbs_pkg::PBS_ACTIVE) ##0
    ctrl.all_lanes_write_n && !ctrl.lane_write_qualify_n && ctrl.lane_write_sel_n != pbs_pkg::LANES_ALL
    |=> r.wr_pend && r.wr_mask == ~$past(ctrl.lane_write_sel_n))
    else $error("lane write mask wrong");
  a_global_write: assert property (
    s_continue ##0 !ctrl.all_lanes_write_n
    |=> r.wr_pend && r.wr_mask == pbs_pkg::LANES_ALL && r.din == $past(pin_word))
    else $error("global write not full width");
  a_write_tristate: assert property (
    r.wr_seen
    |-> !data_oe)
    else $error("pins driven in write cycle");
  a_first_masked: assert property (
    s_select_load ##0 r.st == pbs_pkg::PBS_IDLE && ld_mask == pbs_pkg::LANES_NONE
    |=> !data_oe)
    else $error("first read cycle was driven");
  a_double_desel: assert property (
    s_desel_active ##0 r.drive
    |=> r.st == pbs_pkg::PBS_DRAIN && r.drive)
    else $error("outputs dropped at deselect edge");
  a_desel_release: assert property (
    s_live ##0 !load && r.st == pbs_pkg::PBS_DRAIN
    |=> r.st == pbs_pkg::PBS_IDLE && !r.drive)
    else $error("outputs still driven two edges after deselect");
  a_sleep_quiet: assert property (
    sleep_request
    |-> !data_oe)
    else $error("pins driven during sleep");

endmodule

// >>> hdl/pbs_pkg.sv
// Constants, carrier structs and state layout for the pipelined burst memory port.
// Assumes one clock domain; every user writes pbs_pkg::name.
package pbs_pkg;

  localparam int ADDR_W = 19;
  localparam int LO_W = 2;
  localparam int HI_W = ADDR_W - LO_W;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int DEPTH = 2 ** ADDR_W;

  localparam logic [LO_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [LO_W-1:0] STEP_ONE = 2'h1;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // Access lifecycle: idle, selected, and the extra driven cycle after a deselect.
  typedef enum logic [2:0] {
    PBS_IDLE = 3'b001,
    PBS_ACTIVE = 3'b010,
    PBS_DRAIN = 3'b100
  } pbs_state_t;

  typedef logic [LANES-1:0][LANE_W-1:0] pbs_word_t;

  typedef struct packed {
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic select_first_n;
    logic select_second;
    logic select_third_n;
    logic all_lanes_write_n;
    logic lane_write_qualify_n;
    logic [LANES-1:0] lane_write_sel_n;
  } pbs_ctrl_t;

  typedef struct packed {
    logic [DATA_W-1:0] dq;
    logic [LANES-1:0] parity_lines;
  } pbs_data_t;

  typedef struct packed {
    pbs_state_t st;
    logic [HI_W-1:0] addr_hi;
    logic [LO_W-1:0] start;
    logic [LO_W-1:0] step;
    logic order;
    logic order_taken;
    logic first;
    logic drive;
    logic wr_seen;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_mask;
    pbs_word_t din;
    pbs_word_t dout;
  } pbs_regs_t;

endpackage

// >>> test/pbs_bus_master.sv
// Bus master model for the burst memory port: address, controls and write data.
// Assumes the bench calls cyc once per clock; every change lands at the falling edge.
`timescale 1ns/1ps

module pbs_bus_master (
  // Clock.
  input wire logic sys_clk,
  // Towards the port.
  output logic [pbs_pkg::HI_W-1:0] addr_hi,
  output logic burst_addr_bit1,
  output logic burst_addr_bit0,
  output pbs_pkg::pbs_ctrl_t ctrl,
  output pbs_pkg::pbs_data_t data_in
);
  initial begin
    ctrl = pbs_pkg::pbs_ctrl_t'(12'hebf);
    {addr_hi, burst_addr_bit1, burst_addr_bit0} = 19'h00000;
    data_in = pbs_pkg::pbs_data_t'(36'h0);
  end

  // A released bus must not look like the last write, so idle cycles invert it.
  task automatic cyc(input logic [11:0] c, input logic [18:0] a, input logic [35:0] d);
    @(negedge sys_clk);
    ctrl = pbs_pkg::pbs_ctrl_t'(c);
    {addr_hi, burst_addr_bit1, burst_addr_bit0} = a;
    if (!c[5] || !c[4]) begin
      data_in = pbs_pkg::pbs_data_t'(d);
    end else begin
      data_in = ~data_in;
    end
  endtask
endmodule

// >>> test/test_pbs_burst_port.sv
// Self-checking bench for the pipelined burst memory port, driven by a bus master model.
// Assumes the port's own assertions run inside the design; clock 250 MHz.
`timescale 1ns/1ps

module test_pbs_burst_port;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic out_drive_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_order = 1'b0;
  logic [pbs_pkg::HI_W-1:0] addr_hi;
  logic burst_addr_bit1;
  logic burst_addr_bit0;
  pbs_pkg::pbs_ctrl_t ctrl;
  pbs_pkg::pbs_data_t data_in;
  pbs_pkg::pbs_data_t data_out;
  logic data_oe;
  int err_count = 0;
  int check_count = 0;
  logic [35:0] mem [4];
  localparam logic [18:0] BASE = 19'h12340;

  always #2 sys_clk = ~sys_clk;

  pbs_bus_master u_pbs_bus_master (.sys_clk(sys_clk), .addr_hi(addr_hi),
    .burst_addr_bit1(burst_addr_bit1), .burst_addr_bit0(burst_addr_bit0), .ctrl(ctrl),
    .data_in(data_in));

  pbs_burst_port u_pbs_burst_port (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
    .addr_hi(addr_hi), .burst_addr_bit1(burst_addr_bit1), .burst_addr_bit0(burst_addr_bit0),
    .ctrl(ctrl), .out_drive_n(out_drive_n), .sleep_request(sleep_request),
    .burst_order(burst_order), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  // ****************************************
  // Tasks and scenarios
  // ****************************************
  task automatic chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Each call shows, on return, what the port did at the previous rising edge.
  task automatic cyc(input logic [11:0] c, input logic [18:0] a = BASE,
                     input logic [35:0] d = 36'h0);
    u_pbs_bus_master.cyc(c, a, d);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The strap only changes while reset is held.
  task automatic do_reset(input logic order);
    rstn = 1'b0;
    burst_order = order;
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    cyc(12'hebf);
  endtask

  // A deselect first, so the read below always emerges from a deselected port.
  task automatic burst(input logic [1:0] st);
    cyc(12'ha3f);
    cyc(12'habf, BASE + 19'(st));
    cyc(12'hcbf);
    chk("first read oe", 36'(data_oe), 36'h0);
    chk("burst start", data_out, mem[st]);
    for (int k = 1; k < 5; k++) begin
      cyc(k == 2 ? 12'hc3f : 12'hcbf);
      chk("burst data", data_out, mem[burst_order ? st ^ 2'(k) : st + 2'(k)]);
      chk("burst oe", 36'(data_oe), 36'h1);
    end
  endtask

  // Follows a linear burst from 2 that has stepped once past its wrap, so one more step
  // lands on location 0 if the processor strobe is really ignored.
  task automatic desel_test();
    cyc(12'h5bf, BASE + 19'h8);
    out_drive_n = 1'b1;
    #1;
    chk("oe released", 36'(data_oe), 36'h0);
    out_drive_n = 1'b0;
    cyc(12'ha3f);
    chk("proc ignored", data_out, mem[0]);
    cyc(12'hebf);
    chk("deselect hold", 36'(data_oe), 36'h1);
    cyc(12'hebf);
    chk("deselect off", 36'(data_oe), 36'h0);
  endtask

  // A strobe presented while the enable is low must leave the read data untouched.
  task automatic freeze_test();
    clk_en = 1'b0;
    cyc(12'habf, BASE + 19'h3);
    cyc(12'hebf);
    chk("frozen data", data_out, mem[0]);
    clk_en = 1'b1;
  endtask

  task automatic lane_write();
    cyc(12'habf, BASE + 19'h1);
    cyc(12'hebf);
    cyc(12'haaa, BASE + 19'h1, {9{4'hc}});
    chk("oe before write", 36'(data_oe), 36'h1);
    cyc(12'hab0, BASE + 19'h1);
    chk("oe in write", 36'(data_oe), 36'h0);
    mem[1] = (mem[1] & ~36'h00ff00ff5) | ({9{4'hc}} & 36'h00ff00ff5);
    cyc(12'hebf);
    chk("lane write", data_out, mem[1]);
  endtask

  task automatic dual_strobe();
    cyc(12'h29f, BASE, 36'h0);
    cyc(12'he9f, BASE, {9{4'h9}});
    chk("dual strobe read", data_out, mem[0]);
    mem[0] = {9{4'h9}};
    cyc(12'habf);
    cyc(12'hebf);
    chk("proc write", data_out, mem[0]);
  endtask

  task automatic sleep_test();
    sleep_request = 1'b1;
    cyc(12'ha9f, BASE + 19'h2, 36'h0);
    chk("sleep oe", 36'(data_oe), 36'h0);
    cyc(12'hebf);
    sleep_request = 1'b0;
    cyc(12'habf, BASE + 19'h2);
    cyc(12'hebf);
    chk("sleep keeps", data_out, mem[2]);
  endtask

  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      mem[i] = {9{4'(i + 3)}};
      cyc(12'ha9f, BASE + 19'(i), mem[i]);
    end
    burst(2'h2);
    desel_test();
    lane_write();
    dual_strobe();
    freeze_test();
    sleep_test();
    do_reset(1'b1);
    burst(2'h1);
    end_of_test();
  end

  // The whole run takes under 150 cycles, so 2000 means a hang.
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end
endmodule
